// [adcrb_pkg.sv]
// package for the converter register bank: offsets, fields, reset values, codes
package adcrb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h00;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFF_CTRL0       = 8'h08;
  localparam logic [7:0] OFF_CTRL1       = 8'h0C;
  localparam logic [7:0] OFF_CTRL2       = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C0_START   = 7;
  localparam int C0_BUSY    = 6;
  localparam int C0_ENABLE  = 5;
  localparam int C0_JUSTIFY = 4;
  localparam int C0_CHAN_LO = 0;
  localparam int C1_SRC_LO  = 5;
  localparam int C1_DIV_LO  = 0;
  localparam int C2_AMPEN   = 7;
  localparam int C2_BGEN    = 6;
  localparam int C2_REF_LO  = 0;

  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] C0_WMASK = 8'hB7;
  localparam logic [7:0] C1_WMASK = 8'hE7;
  localparam logic [7:0] C2_WMASK = 8'hCF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // ----------------------------------------------------------------
  // timing counts, in conversion clock cycles
  // ----------------------------------------------------------------
  localparam int SAMPLE_CYCLES  = 4;
  localparam int CONVERT_CYCLES = 12;
  localparam int TOTAL_CYCLES   = SAMPLE_CYCLES + CONVERT_CYCLES;

  // ----------------------------------------------------------------
  // source and reference codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PIN, SRC_SUPPLY, SRC_SUPPLY_HALF, SRC_SUPPLY_QTR,
    SRC_AMP, SRC_AMP_HALF, SRC_AMP_QTR
  } adcrb_src_type;

  typedef enum logic [2:0] {
    REF_SUPPLY, REF_EXT1, REF_EXT2, REF_EXT3, REF_EXT4,
    REF_BG2, REF_BG3, REF_BG4
  } adcrb_ref_type;

  // ----------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          powerOn;
    logic          ampEnable;
    logic          bandgapBufEnable;
    logic          ampFromBandgap;
    adcrb_src_type source;
    adcrb_ref_type reference;
    logic [7:0]    pinAnalog;
    logic          sampling;
  } adcrb_analog_type;

endpackage

// [adcrb_top.sv]
// converter control and result register bank with an AXI4-Lite slave
// ----------------------------------------------------------------
// Functional notes
// - justify 0: left aligned, low nibble zero
// - justify 1: right aligned, high nibble zero
// - unused and unimplemented bits read zero
// - disabling keeps result registers
// - start rising resets converter, clears busy
// - start high then low launches, busy set
// - busy bit 6 shows conversion in progress
// - enable bit 5 powers converter
// - channel code N routes pin N
// - source 000 takes chosen pin only
// - source 001-011 supply, half, quarter
// - source 101-111 amplifier, half, quarter
// - source 100 acts as 000
// - internal source wins over pin
// - conversion clock is system clock over 2^code
// - reference code map supply, external, bandgap
// - code 1001 forbidden, others mean supply
// - reference top bit feeds amplifier bandgap
// - bandgap wins over external reference
// - bandgap buffer enable at bit 6
// - analog pin drops digital use, pull-high
// - 4 sample plus 12 convert cycles
// - completion clears busy, writes result, flags
// ----------------------------------------------------------------
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module adcrb_top
  import adcrb_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [7:0]       sAxiAwaddr,
  input  wire logic             sAxiAwvalid,
  output logic                  sAxiAwready,
  input  wire logic [31:0]      sAxiWdata,
  input  wire logic [3:0]       sAxiWstrb,
  input  wire logic             sAxiWvalid,
  output logic                  sAxiWready,
  output logic [1:0]            sAxiBresp,
  output logic                  sAxiBvalid,
  input  wire logic             sAxiBready,
  input  wire logic [7:0]       sAxiAraddr,
  input  wire logic             sAxiArvalid,
  output logic                  sAxiArready,
  output logic [31:0]           sAxiRdata,
  output logic [1:0]            sAxiRresp,
  output logic                  sAxiRvalid,
  input  wire logic             sAxiRready,
  input  wire logic [11:0]      pinLevel [8],
  input  wire logic [11:0]      internalLevel,
  output adcrb_analog_type      analogCtrl,
  output logic                  convDone
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstSync1_reg, rstN_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_reg <= 1'b0;
      rstN_reg     <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN_reg     <= rstSync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic [7:0]  awAddr_reg, ctrl0_reg, ctrl1_reg, ctrl2_reg;
  logic        awHave_reg, wHave_reg;
  logic [7:0]  wByte_reg;
  logic        wLane_reg;
  logic [11:0] result_reg;
  logic        busy_reg, convDone_reg;

  wire doWrite   = awHave_reg && wHave_reg && !sAxiBvalid;
  wire wrMapped  = (awAddr_reg == OFF_RESULT_LOW) || (awAddr_reg == OFF_RESULT_HIGH) ||
                   (awAddr_reg == OFF_CTRL0) || (awAddr_reg == OFF_CTRL1) ||
                   (awAddr_reg == OFF_CTRL2);
  wire wrC0      = doWrite && wLane_reg && awAddr_reg == OFF_CTRL0;
  wire wrC1      = doWrite && wLane_reg && awAddr_reg == OFF_CTRL1;
  wire wrC2      = doWrite && wLane_reg && awAddr_reg == OFF_CTRL2;
  // busy is hardware owned, so bit 6 of the stored copy is never written
  wire [7:0] ctrl0_next = wByte_reg & C0_WMASK;
  wire [7:0] ctrl1_next = wByte_reg & C1_WMASK;
  wire [7:0] ctrl2_next = wByte_reg & C2_WMASK;

  assign sAxiAwready = !awHave_reg;
  assign sAxiWready  = !wHave_reg;

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wByte_reg  <= 8'h00;
      wLane_reg  <= 1'b0;
      sAxiBvalid <= 1'b0;
      sAxiBresp  <= 2'h0;
    end else begin
      if (sAxiAwvalid && sAxiAwready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= {sAxiAwaddr[7:2], 2'h0};
      end
      if (sAxiWvalid && sAxiWready) begin
        wHave_reg <= 1'b1;
        wByte_reg <= sAxiWdata[7:0];
        wLane_reg <= sAxiWstrb[0];
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        sAxiBvalid <= 1'b1;
        sAxiBresp  <= wrMapped ? 2'h0 : 2'h2;
      end else if (sAxiBready) begin
        sAxiBvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      ctrl0_reg <= CTRL_RESET;
      ctrl1_reg <= CTRL_RESET;
      ctrl2_reg <= CTRL_RESET;
    end else begin
      if (wrC0) ctrl0_reg <= ctrl0_next;
      if (wrC1) ctrl1_reg <= ctrl1_next;
      if (wrC2) ctrl2_reg <= ctrl2_next;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire       startBit  = ctrl0_reg[C0_START];
  wire       enable    = ctrl0_reg[C0_ENABLE];
  wire       justify   = ctrl0_reg[C0_JUSTIFY];
  wire [2:0] chanSel   = ctrl0_reg[C0_CHAN_LO +: 3];
  wire [2:0] srcSel    = ctrl1_reg[C1_SRC_LO +: 3];
  wire [2:0] divSel    = ctrl1_reg[C1_DIV_LO +: 3];
  wire [3:0] refSel    = ctrl2_reg[C2_REF_LO +: 4];
  wire       startRise = wrC0 && !startBit && ctrl0_next[C0_START];
  wire       startFall = wrC0 && startBit && !ctrl0_next[C0_START];

  // unassigned source 100 falls back to the pin, any other internal code wins
  adcrb_src_type srcDecoded;
  always_comb begin
    unique case (srcSel)
      3'h1:    srcDecoded = SRC_SUPPLY;
      3'h2:    srcDecoded = SRC_SUPPLY_HALF;
      3'h3:    srcDecoded = SRC_SUPPLY_QTR;
      3'h5:    srcDecoded = SRC_AMP;
      3'h6:    srcDecoded = SRC_AMP_HALF;
      3'h7:    srcDecoded = SRC_AMP_QTR;
      default: srcDecoded = SRC_PIN;
    endcase
  end

  // 1001 is forbidden to software and simply lands in the supply default
  adcrb_ref_type refDecoded;
  always_comb begin
    unique case (refSel)
      4'h1:    refDecoded = REF_EXT1;
      4'h2:    refDecoded = REF_EXT2;
      4'h3:    refDecoded = REF_EXT3;
      4'h4:    refDecoded = REF_EXT4;
      4'hA:    refDecoded = REF_BG2;
      4'hB:    refDecoded = REF_BG3;
      4'hC:    refDecoded = REF_BG4;
      default: refDecoded = REF_SUPPLY;
    endcase
  end

  // ----------------------------------------------------------------
  // conversion clock divider and sequencer
  // ----------------------------------------------------------------
  logic [6:0] divCnt_reg;
  logic [4:0] phase_reg;
  logic [7:0] divTerm;
  assign divTerm = 8'h01 << divSel;
  wire adcTick = ({1'b0, divCnt_reg} == divTerm - 8'h01);

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      divCnt_reg <= 7'h00;
    end else if (adcTick || startFall) begin
      divCnt_reg <= 7'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 7'h01;
    end
  end

  wire lastTick = busy_reg && adcTick && phase_reg == 5'(TOTAL_CYCLES - 1);

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      busy_reg     <= 1'b0;
      phase_reg    <= 5'h00;
      convDone_reg <= 1'b0;
      result_reg   <= RESULT_RESET;
    end else begin
      convDone_reg <= 1'b0;
      if (startRise || !enable) begin
        busy_reg  <= 1'b0;
        phase_reg <= 5'h00;
      end else if (startFall) begin
        busy_reg  <= 1'b1;
        phase_reg <= 5'h00;
      end else if (lastTick) begin
        busy_reg     <= 1'b0;
        convDone_reg <= 1'b1;
        result_reg   <= (srcDecoded == SRC_PIN) ? pinLevel[chanSel] : internalLevel;
      end else if (busy_reg && adcTick) begin
        phase_reg <= phase_reg + 5'h01;
      end
    end
  end
  // result_reg has no clear on disable

  assign convDone = convDone_reg;

  // ----------------------------------------------------------------
  // analog side
  // ----------------------------------------------------------------
  always_comb begin
    analogCtrl.powerOn          = enable;
    analogCtrl.ampEnable        = ctrl2_reg[C2_AMPEN];
    analogCtrl.bandgapBufEnable = ctrl2_reg[C2_BGEN];
    analogCtrl.ampFromBandgap   = refSel[3];
    analogCtrl.source           = srcDecoded;
    analogCtrl.reference        = refDecoded;
    // a pin given to the converter loses digital function and pull-high
    analogCtrl.pinAnalog        = (enable && srcDecoded == SRC_PIN) ? 8'h01 << chanSel : 8'h00;
    analogCtrl.sampling         = busy_reg && phase_reg < 5'(SAMPLE_CYCLES);
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] resLow  = justify ? result_reg[7:0] : {result_reg[3:0], 4'h0};
  wire [7:0] resHigh = justify ? {4'h0, result_reg[11:8]} : result_reg[11:4];
  wire [7:0] arAddr  = {sAxiAraddr[7:2], 2'h0};
  logic [7:0] rdByte;
  logic       rdOk;
  always_comb begin
    rdOk = 1'b1;
    unique case (arAddr)
      OFF_RESULT_LOW:  rdByte = resLow;
      OFF_RESULT_HIGH: rdByte = resHigh;
      OFF_CTRL0:       rdByte = ctrl0_reg | {1'b0, busy_reg, 6'h00};
      OFF_CTRL1:       rdByte = ctrl1_reg;
      OFF_CTRL2:       rdByte = ctrl2_reg;
      default: begin
        rdByte = 8'h00;
        rdOk   = 1'b0;
      end
    endcase
  end

  assign sAxiArready = !sAxiRvalid;

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      sAxiRvalid <= 1'b0;
      sAxiRdata  <= 32'h0000_0000;
      sAxiRresp  <= 2'h0;
    end else if (sAxiArvalid && sAxiArready) begin
      sAxiRvalid <= 1'b1;
      sAxiRdata  <= {24'h00_0000, rdByte};
      sAxiRresp  <= rdOk ? 2'h0 : 2'h2;
    end else if (sAxiRready) begin
      sAxiRvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // span of the busy flag in system clocks, read only by the length check
  logic [11:0] busyLen_reg;
  logic        divHeld_reg;
  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      busyLen_reg <= 12'h000;
      divHeld_reg <= 1'b0;
    end else if (startFall) begin
      busyLen_reg <= 12'h000;
      divHeld_reg <= 1'b1;
    end else begin
      busyLen_reg <= busyLen_reg + 12'h001;
      if (wrC1) divHeld_reg <= 1'b0;
    end
  end

  a_rise_clears_busy: assert property (@(posedge mclk) disable iff (!rstN_reg)
    startRise |=> !busy_reg) else $error("start rise left busy set");
  a_fall_sets_busy: assert property (@(posedge mclk) disable iff (!rstN_reg)
    startFall && enable |=> busy_reg) else $error("start fall did not set busy");
  a_done_clears_busy: assert property (@(posedge mclk) disable iff (!rstN_reg)
    convDone_reg |-> !busy_reg && $fell(busy_reg)) else $error("done without busy end");
  a_result_kept_off: assert property (@(posedge mclk) disable iff (!rstN_reg)
    !enable && !convDone_reg |=> $stable(result_reg)) else $error("result changed while off");
  a_justify_zero: assert property (@(posedge mclk) disable iff (!rstN_reg)
    !justify |-> resLow[3:0] == 4'h0 && resHigh == result_reg[11:4]) else $error("left justify wrong");
  a_justify_one: assert property (@(posedge mclk) disable iff (!rstN_reg)
    justify |-> resHigh[7:4] == 4'h0 && resLow == result_reg[7:0]) else $error("right justify wrong");
  a_src_four_pin: assert property (@(posedge mclk) disable iff (!rstN_reg)
    srcSel == 3'h4 |-> srcDecoded == SRC_PIN) else $error("source 100 not pin");
  a_ref_bandgap_amp: assert property (@(posedge mclk) disable iff (!rstN_reg)
    refSel[3] |-> analogCtrl.ampFromBandgap) else $error("amplifier not on bandgap");
  a_ref_forbidden: assert property (@(posedge mclk) disable iff (!rstN_reg)
    refSel == 4'h9 |-> refDecoded == REF_SUPPLY) else $error("1001 not supply");
  a_divide_one_len: assert property (@(posedge mclk) disable iff (!rstN_reg)
    startFall && enable && divSel == 3'h0 && !wrC1 ##1 (enable && !wrC0 && !wrC1)[*8]
    |-> busy_reg && !convDone_reg) else $error("conversion ended early");
  a_busy_read: assert property (@(posedge mclk) disable iff (!rstN_reg)
    arAddr == OFF_CTRL0 |-> rdByte[C0_BUSY] == busy_reg && rdByte[3] == 1'b0) else $error("bad busy read");
  a_conv_length: assert property (@(posedge mclk) disable iff (!rstN_reg)
    convDone_reg && divHeld_reg |-> busyLen_reg == 12'(TOTAL_CYCLES << divSel))
    else $error("conversion length wrong");
  a_disable_clears_busy: assert property (@(posedge mclk) disable iff (!rstN_reg)
    !enable |=> !busy_reg) else $error("busy kept while disabled");
  a_launch_samples: assert property (@(posedge mclk) disable iff (!rstN_reg)
    startFall && enable |=> analogCtrl.sampling) else $error("launch did not sample");
  a_rise_stops_work: assert property (@(posedge mclk) disable iff (!rstN_reg)
    startRise |=> !analogCtrl.sampling && !convDone_reg) else $error("start rise left work running");
  a_done_pulse: assert property (@(posedge mclk) disable iff (!rstN_reg)
    convDone_reg |=> !convDone_reg) else $error("done longer than one cycle");
  a_result_only_done: assert property (@(posedge mclk) disable iff (!rstN_reg)
    !convDone_reg |-> $stable(result_reg)) else $error("result changed without done");
  a_src_zero_pin: assert property (@(posedge mclk) disable iff (!rstN_reg)
    srcSel == 3'h0 |-> srcDecoded == SRC_PIN) else $error("source 000 not pin");
  a_internal_no_pin: assert property (@(posedge mclk) disable iff (!rstN_reg)
    srcDecoded != SRC_PIN |-> analogCtrl.pinAnalog == 8'h00) else $error("pin routed with internal source");
  a_pin_onehot: assert property (@(posedge mclk) disable iff (!rstN_reg)
    enable && srcDecoded == SRC_PIN |-> analogCtrl.pinAnalog[chanSel] && $onehot(analogCtrl.pinAnalog))
    else $error("chosen pin not routed alone");
  a_bandgap_wins: assert property (@(posedge mclk) disable iff (!rstN_reg)
    refSel[3] |-> refDecoded inside {REF_SUPPLY, REF_BG2, REF_BG3, REF_BG4})
    else $error("external reference with bandgap");
  a_ctrl1_gaps_zero: assert property (@(posedge mclk) disable iff (!rstN_reg)
    arAddr == OFF_CTRL1 |-> rdByte[4:3] == 2'h0) else $error("control 1 gap not zero");
  a_ctrl2_gaps_zero: assert property (@(posedge mclk) disable iff (!rstN_reg)
    arAddr == OFF_CTRL2 |-> rdByte[5:4] == 2'h0) else $error("control 2 gap not zero");
  a_rdata_high_zero: assert property (@(posedge mclk) disable iff (!rstN_reg)
    sAxiRvalid |-> sAxiRdata[31:8] == 24'h00_0000) else $error("upper read bits not zero");

  // ----------------------------------------------------------------
  // bus protocol checks
  // ----------------------------------------------------------------
  a_bvalid_hold: assert property (@(posedge mclk) disable iff (!rstN_reg)
    sAxiBvalid && !sAxiBready |=> sAxiBvalid && $stable(sAxiBresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (@(posedge mclk) disable iff (!rstN_reg)
    sAxiRvalid && !sAxiRready |=> sAxiRvalid && $stable(sAxiRdata)) else $error("read response dropped");
  a_write_slverr: assert property (@(posedge mclk) disable iff (!rstN_reg)
    doWrite && !wrMapped |=> sAxiBvalid && sAxiBresp == 2'h2) else $error("unmapped write not refused");
  a_read_slverr: assert property (@(posedge mclk) disable iff (!rstN_reg)
    sAxiArvalid && sAxiArready && !rdOk |=> sAxiRresp == 2'h2 && sAxiRdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  c_conversion_done: cover property (@(posedge mclk) disable iff (!rstN_reg) convDone_reg);
  c_internal_source: cover property (@(posedge mclk) disable iff (!rstN_reg) convDone_reg && srcDecoded != SRC_PIN);
  c_reset_mid_conv: cover property (@(posedge mclk) disable iff (!rstN_reg) busy_reg && startRise);
  c_right_justify: cover property (@(posedge mclk) disable iff (!rstN_reg) convDone_reg && justify);
  c_slowest_clock: cover property (@(posedge mclk) disable iff (!rstN_reg) convDone_reg && divSel == 3'h7);

endmodule

// [adc_control_register_bank_tb.sv]
// self-checking bench for the converter register bank
`timescale 1ns/1ps
module adc_control_register_bank_tb;
  import adcrb_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic             mclk = 1'b0;
  logic             arst_n;
  logic [7:0]       sAxiAwaddr;
  logic             sAxiAwvalid;
  logic             sAxiAwready;
  logic [31:0]      sAxiWdata;
  logic [3:0]       sAxiWstrb;
  logic             sAxiWvalid;
  logic             sAxiWready;
  logic [1:0]       sAxiBresp;
  logic             sAxiBvalid;
  logic             sAxiBready;
  logic [7:0]       sAxiAraddr;
  logic             sAxiArvalid;
  logic             sAxiArready;
  logic [31:0]      sAxiRdata;
  logic [1:0]       sAxiRresp;
  logic             sAxiRvalid;
  logic             sAxiRready;
  logic [11:0]      pinLevel [8];
  logic [11:0]      internalLevel;
  adcrb_analog_type analogCtrl;
  logic             convDone;
  int               mismatches = 0;
  int               checksDone = 0;
  logic [31:0]      rdat;
  logic [1:0]       resp;
  logic [11:0]      lvl;
  int               cyc;

  always #20 mclk = ~mclk;

  adcrb_top dut_u (
    .mclk(mclk), .arst_n(arst_n), .sAxiAwaddr(sAxiAwaddr), .sAxiAwvalid(sAxiAwvalid),
    .sAxiAwready(sAxiAwready), .sAxiWdata(sAxiWdata), .sAxiWstrb(sAxiWstrb), .sAxiWvalid(sAxiWvalid),
    .sAxiWready(sAxiWready), .sAxiBresp(sAxiBresp), .sAxiBvalid(sAxiBvalid), .sAxiBready(sAxiBready),
    .sAxiAraddr(sAxiAraddr), .sAxiArvalid(sAxiArvalid), .sAxiArready(sAxiArready), .sAxiRdata(sAxiRdata),
    .sAxiRresp(sAxiRresp), .sAxiRvalid(sAxiRvalid), .sAxiRready(sAxiRready), .pinLevel(pinLevel),
    .internalLevel(internalLevel), .analogCtrl(analogCtrl), .convDone(convDone)
  );

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task stop_test;
    if (mismatches == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled in the active region, so it still shows its pre-edge value
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic b;
    b = 1'b0;
    @(posedge mclk);
    sAxiAwaddr  <= a;
    sAxiAwvalid <= 1'b1;
    sAxiWdata   <= {24'h000000, d};
    sAxiWvalid  <= 1'b1;
    sAxiBready  <= 1'b1;
    while (!b) begin
      @(posedge mclk);
      if (sAxiAwvalid && sAxiAwready) sAxiAwvalid <= 1'b0;
      if (sAxiWvalid && sAxiWready) sAxiWvalid <= 1'b0;
      if (sAxiBvalid && sAxiBready) begin
        resp = sAxiBresp;
        b = 1'b1;
        sAxiBready <= 1'b0;
      end
    end
  endtask

  task rd(input logic [7:0] a);
    logic b;
    b = 1'b0;
    @(posedge mclk);
    sAxiAraddr  <= a;
    sAxiArvalid <= 1'b1;
    sAxiRready  <= 1'b1;
    while (!b) begin
      @(posedge mclk);
      if (sAxiArvalid && sAxiArready) sAxiArvalid <= 1'b0;
      if (sAxiRvalid && sAxiRready) begin
        rdat = sAxiRdata;
        resp = sAxiRresp;
        b = 1'b1;
        sAxiRready <= 1'b0;
      end
    end
  endtask

  // start high then low, then count cycles to the completion pulse
  task conv(input logic [7:0] c0);
    int n;
    wr(OFF_CTRL0, c0 | 8'h80);
    wr(OFF_CTRL0, c0);
    cyc = 0;
    for (n = 0; n < 4096 && !convDone; n++) begin
      @(posedge mclk);
      cyc++;
    end
    chk(32'(convDone), 32'h1);
    rd(OFF_CTRL0);
    chk(rdat, {24'h0, c0});
  endtask

  function automatic adcrb_ref_type refExp(input int c);
    if (c >= 1 && c <= 4) return adcrb_ref_type'(3'(c));
    if (c >= 10 && c <= 12) return adcrb_ref_type'(3'(c - 5));
    return REF_SUPPLY;
  endfunction

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under 20000 cycles
  // ----------------------------------------------------------------
  initial begin
    #(60000 * 40);
    mismatches++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    sAxiAwaddr = 8'h00;
    sAxiAwvalid = 1'b0;
    sAxiWdata = 32'h00000000;
    sAxiWstrb = 4'hF;
    sAxiWvalid = 1'b0;
    sAxiBready = 1'b0;
    sAxiAraddr = 8'h00;
    sAxiArvalid = 1'b0;
    sAxiRready = 1'b0;
    internalLevel = 12'h3C5;
    for (int i = 0; i < 8; i++) pinLevel[i] = {4'(i + 8), 4'(15 - i), 4'(i + 3)};
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i));
      chk(rdat, 32'h00000000);
    end
    // busy is read-only and bit 3 unimplemented, so 0x5F reads back 0x17
    wr(OFF_CTRL0, 8'h5F);
    rd(OFF_CTRL0);
    chk(rdat, 32'h00000017);
    wr(OFF_CTRL1, 8'hFF);
    rd(OFF_CTRL1);
    chk(rdat, 32'h000000E7);
    wr(OFF_CTRL2, 8'hFF);
    rd(OFF_CTRL2);
    chk(rdat, 32'h000000CF);
    wr(OFF_CTRL1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      conv(8'h20 | 8'(i));
      rd(OFF_RESULT_HIGH);
      chk(rdat, {24'h0, pinLevel[i][11:4]});
      rd(OFF_RESULT_LOW);
      chk(rdat, {24'h0, pinLevel[i][3:0], 4'h0});
      chk(32'(analogCtrl.pinAnalog), 32'(8'h01 << i));
    end
    conv(8'h33);
    rd(OFF_RESULT_HIGH);
    chk(rdat, {28'h0, pinLevel[3][11:8]});
    rd(OFF_RESULT_LOW);
    chk(rdat, {24'h0, pinLevel[3][7:0]});
    for (int s = 1; s < 8; s++) begin
      internalLevel <= 12'(s * 12'h111);
      wr(OFF_CTRL1, 8'(s << 5));
      conv(8'h22);
      lvl = (s == 4) ? pinLevel[2] : internalLevel;
      chk(32'(analogCtrl.source), (s < 4) ? s : (s == 4) ? 0 : s - 1);
      chk(32'(analogCtrl.pinAnalog), (s == 4) ? 32'h4 : 32'h0);
      rd(OFF_RESULT_HIGH);
      chk(rdat, {24'h0, lvl[11:4]});
    end
    // the divider restarts at the launch, so the first conversion clock comes one divided period later
    for (int k = 0; k < 8; k++) begin
      wr(OFF_CTRL1, 8'(k));
      conv(8'h20);
      chk(32'(cyc >= (16 << k) - 4 && cyc <= (17 << k) + 4), 32'h1);
    end
    wr(OFF_CTRL0, 8'hA1);
    wr(OFF_CTRL0, 8'h21);
    chk(32'(analogCtrl.sampling), 32'h1);
    rd(OFF_CTRL0);
    chk(rdat, 32'h00000061);
    wr(OFF_CTRL0, 8'hA1);
    rd(OFF_CTRL0);
    chk(rdat, 32'h000000A1);
    chk(32'(analogCtrl.sampling), 32'h0);
    wr(OFF_CTRL0, 8'h21);
    wr(OFF_CTRL0, 8'h01);
    rd(OFF_CTRL0);
    chk(rdat, 32'h00000001);
    chk(32'(analogCtrl.powerOn), 32'h0);
    wr(OFF_RESULT_HIGH, 8'hFF);
    chk(32'(resp), 32'h0);
    rd(OFF_RESULT_HIGH);
    chk(rdat, {24'h0, pinLevel[0][11:4]});
    rd(8'h14);
    chk(32'(resp), 32'h2);
    chk(rdat, 32'h00000000);
    wr(8'h14, 8'h55);
    chk(32'(resp), 32'h2);
    // code 1001 must never be programmed, so the loop leaves it out
    for (int r = 0; r < 16; r++) begin
      if (r != 9) begin
        wr(OFF_CTRL2, 8'hC0 | 8'(r));
        chk(32'(analogCtrl.reference), 32'(refExp(r)));
        chk(32'(analogCtrl.ampFromBandgap), 32'(r >> 3));
        chk(32'({analogCtrl.ampEnable, analogCtrl.bandgapBufEnable}), 32'h3);
      end
    end
    wr(OFF_CTRL2, 8'h00);
    chk(32'({analogCtrl.ampEnable, analogCtrl.bandgapBufEnable}), 32'h0);
    stop_test;
  end
endmodule
